// ===== verilog/bbnio_pkg.sv
// Package: register map, field layout and reset values for the bus number and I/O window block
package bbnio_pkg;
    // ------------------------------------------------------------
    // Byte offsets of the configuration header bytes
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_UPSTREAM_BUS = 12'h018;
    localparam logic [11:0] OFS_DOWNSTREAM_BUS = 12'h019;
    localparam logic [11:0] OFS_HIGHEST_BUS = 12'h01A;
    localparam logic [11:0] OFS_LATENCY_TIMER = 12'h01B;
    localparam logic [11:0] OFS_IO_BASE = 12'h01C;
    localparam logic [11:0] OFS_IO_LIMIT = 12'h01D;
    // Word holding all four bytes 0x018..0x01B, and the one holding 0x01C..0x01F
    localparam logic [9:0] WORD_BUS_NUMBERS = 10'h006;
    localparam logic [9:0] WORD_IO_WINDOW = 10'h007;
    // Extra control word: lockable-write enable at bit 0
    localparam logic [9:0] WORD_LOCK_CTRL = 10'h040;
    localparam int LOCK_EN_BIT = 0;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int IO_CAP_BIT = 0;
    localparam int IO_ADDR_LSB = 4;
    localparam int IO_ADDR_MSB = 7;
    localparam logic [7:0] BUS_NUMBER_RESET = 8'h00;
    localparam logic [7:0] LATENCY_TIMER_VALUE = 8'h00;
    localparam logic IO_CAP_RESET = 1'h1;
    localparam logic [3:0] IO_BASE_RESET = 4'hF;
    localparam logic [3:0] IO_LIMIT_RESET = 4'h0;
    localparam logic [11:0] IO_LOW_FILL = 12'h000;
    localparam logic [11:0] IO_HIGH_FILL = 12'hFFF;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// ===== verilog/bbnio_regs.sv
// Module: bus number registers and I/O window decode, Avalon-MM slave
// How it works
// - Upstream bus number: RW byte, resets zero
// - Downstream bus number: RW byte, resets zero
// - Highest bus behind: RW byte, resets zero
// - Latency timer reads zero, writes ignored
// - Base bit 0 reports I/O addressing capability
// - Capability resets one, lockable write only
// - Limit bit 0 mirrors capability bit
// - Base bits 7:4 RW, reset F
// - Limit bits 7:4 RW, reset zero, low FFF
// - Base and limit decide I/O forwarding
`timescale 1ns/1ps
module bbnio_regs (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic io_check_valid,
    input wire logic [31:0] io_check_addr,
    output logic io_forward,
    output logic io_forward_valid,
    output logic [7:0] upstream_bus_number,
    output logic [7:0] downstream_bus_number,
    output logic [7:0] highest_bus_behind,
    output logic io_addressing_capability
);
    // ------------------------------------------------------------
    // Bus handshake: one wait cycle, answer on the second edge
    // ------------------------------------------------------------
    logic ack_r;
    logic [9:0] word;
    logic wr_go;
    logic rd_go;
    assign word = avs_address[11:2];
    // Write lands at the edge where waitrequest is seen low
    assign wr_go = avs_write & ack_r;
    assign rd_go = avs_read & ~ack_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & ~ack_r);
        end
    end

    // ------------------------------------------------------------
    // Bus number bytes
    // ------------------------------------------------------------
    logic [7:0] upstream_bus_r;
    logic [7:0] downstream_bus_r;
    logic [7:0] highest_bus_r;
    logic bus_word_wr;
    assign bus_word_wr = wr_go && (word == bbnio_pkg::WORD_BUS_NUMBERS);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            upstream_bus_r <= bbnio_pkg::BUS_NUMBER_RESET;
        end else if (bus_word_wr && avs_byteenable[0]) begin
            upstream_bus_r <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            downstream_bus_r <= bbnio_pkg::BUS_NUMBER_RESET;
        end else if (bus_word_wr && avs_byteenable[1]) begin
            downstream_bus_r <= avs_writedata[15:8];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            highest_bus_r <= bbnio_pkg::BUS_NUMBER_RESET;
        end else if (bus_word_wr && avs_byteenable[2]) begin
            highest_bus_r <= avs_writedata[23:16];
        end
    end

    // ------------------------------------------------------------
    // Lock control and I/O window fields
    // ------------------------------------------------------------
    logic lock_en_r;
    logic io_cap_r;
    logic [3:0] io_base_r;
    logic [3:0] io_limit_r;
    logic io_word_wr;
    assign io_word_wr = wr_go && (word == bbnio_pkg::WORD_IO_WINDOW);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            lock_en_r <= 1'b0;
        end else if (wr_go && word == bbnio_pkg::WORD_LOCK_CTRL && avs_byteenable[0]) begin
            lock_en_r <= avs_writedata[bbnio_pkg::LOCK_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            io_cap_r <= bbnio_pkg::IO_CAP_RESET;
        end else if (io_word_wr && avs_byteenable[0] && lock_en_r) begin
            io_cap_r <= avs_writedata[bbnio_pkg::IO_CAP_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            io_base_r <= bbnio_pkg::IO_BASE_RESET;
        end else if (io_word_wr && avs_byteenable[0]) begin
            io_base_r <= avs_writedata[bbnio_pkg::IO_ADDR_MSB:bbnio_pkg::IO_ADDR_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            io_limit_r <= bbnio_pkg::IO_LIMIT_RESET;
        end else if (io_word_wr && avs_byteenable[1]) begin
            io_limit_r <= avs_writedata[8 + bbnio_pkg::IO_ADDR_MSB:8 + bbnio_pkg::IO_ADDR_LSB];
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] io_base_byte;
    logic [7:0] io_limit_byte;
    logic [31:0] rdata_nxt;
    assign io_base_byte = {io_base_r, 3'h0, io_cap_r};
    assign io_limit_byte = {io_limit_r, 3'h0, io_cap_r};

    always_comb begin
        case (word)
            bbnio_pkg::WORD_BUS_NUMBERS: begin
                rdata_nxt = {bbnio_pkg::LATENCY_TIMER_VALUE, highest_bus_r,
                             downstream_bus_r, upstream_bus_r};
            end
            bbnio_pkg::WORD_IO_WINDOW: begin
                rdata_nxt = {16'h0000, io_limit_byte, io_base_byte};
            end
            bbnio_pkg::WORD_LOCK_CTRL: begin
                rdata_nxt = {31'h0000_0000, lock_en_r};
            end
            default: begin
                rdata_nxt = bbnio_pkg::UNMAPPED_READ;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_go) begin
            avs_readdata <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // I/O window decode, one cycle after the check request
    // ------------------------------------------------------------
    logic [31:0] win_low;
    logic [31:0] win_high;
    logic io_hit;
    always_comb begin
        // 16-bit decode confines the window to the first 64 KB
        win_low = {16'h0000, io_base_r, bbnio_pkg::IO_LOW_FILL};
        win_high = {16'h0000, io_limit_r, bbnio_pkg::IO_HIGH_FILL};
        io_hit = (io_check_addr >= win_low) && (io_check_addr <= win_high);
        if (!io_cap_r && io_check_addr[31:16] != 16'h0000) begin
            io_hit = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            io_forward <= 1'b0;
            io_forward_valid <= 1'b0;
        end else begin
            io_forward <= io_check_valid & io_hit;
            io_forward_valid <= io_check_valid;
        end
    end

    // ------------------------------------------------------------
    // Register copies for the rest of the switch
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            upstream_bus_number <= bbnio_pkg::BUS_NUMBER_RESET;
            downstream_bus_number <= bbnio_pkg::BUS_NUMBER_RESET;
            highest_bus_behind <= bbnio_pkg::BUS_NUMBER_RESET;
            io_addressing_capability <= bbnio_pkg::IO_CAP_RESET;
        end else begin
            upstream_bus_number <= upstream_bus_r;
            downstream_bus_number <= downstream_bus_r;
            highest_bus_behind <= highest_bus_r;
            io_addressing_capability <= io_cap_r;
        end
    end
endmodule // bbnio_regs

// ===== test/bbnio_regs_monitor.sv
// Checker for the bus number and I/O window block
`timescale 1ns/1ps
module bbnio_regs_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic io_check_valid,
    input wire logic [31:0] io_check_addr,
    input wire logic io_forward,
    input wire logic io_forward_valid,
    input wire logic [7:0] upstream_bus_number,
    input wire logic [7:0] downstream_bus_number,
    input wire logic io_addressing_capability
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire ack = !avs_waitrequest;
    wire rd6 = ack && avs_read && avs_address[11:2] == 10'h006;
    wire rd7 = ack && avs_read && avs_address[11:2] == 10'h007;
    wire wr6 = ack && avs_write && avs_address[11:2] == 10'h006;
    a_timer_reads_zero: assert property (rd6 |=> avs_readdata[31:24] == 8'h00)
        else $error("timer byte not zero");
    a_reserved_bits_zero: assert property (rd7 |=> avs_readdata[11:9] == 3'h0
        && avs_readdata[3:1] == 3'h0) else $error("reserved bits set");
    a_limit_cap_mirror: assert property (rd7 |=> avs_readdata[8] == avs_readdata[0])
        else $error("capability mirror differs");
    a_cap_bit_report: assert property (rd7 |=> avs_readdata[0] == io_addressing_capability)
        else $error("capability read differs");
    a_decode_valid_lag: assert property (io_forward_valid == $past(io_check_valid))
        else $error("decode valid lag wrong");
    a_upper_addr_miss: assert property (io_check_valid && |io_check_addr[31:16] |=> !io_forward)
        else $error("upper address forwarded");
    a_upstream_bus_copy: assert property (wr6 && avs_byteenable[0] |=> ##1
        upstream_bus_number == $past(avs_writedata[7:0], 2)) else $error("upstream copy wrong");
    a_downstream_bus_copy: assert property (wr6 && avs_byteenable[1] |=> ##1
        downstream_bus_number == $past(avs_writedata[15:8], 2)) else $error("downstream copy wrong");
endmodule // bbnio_regs_monitor
bind bbnio_regs bbnio_regs_monitor mon (.*);

// ===== test/bbnio_regs_tb_top.sv
// Testbench for the bus number and I/O window block
`timescale 1ns/1ps
module bbnio_regs_tb_top;
    logic clk = 0, resetn = 0, avs_read = 0, avs_write = 0, avs_waitrequest, io_check_valid = 0;
    logic [11:0] avs_address = 12'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, io_check_addr = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic io_forward, io_forward_valid, io_addressing_capability;
    logic [7:0] upstream_bus_number, downstream_bus_number, highest_bus_behind;
    int mismatches = 0, cmp_count = 0, cycles = 0;
    bbnio_regs uut (.*);
    initial forever #20 clk = ~clk;
    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task req(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        @(posedge clk);
        while (avs_waitrequest) @(posedge clk);
        avs_write <= 0;
        avs_read <= 0;
        @(negedge clk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        req(a, 0, 32'h0, 4'hF);
        chk(avs_readdata, e);
    endtask
    task dec(input logic [31:0] a, input logic e);
        @(posedge clk);
        io_check_valid <= 1;
        io_check_addr <= a;
        @(posedge clk);
        io_check_valid <= 0;
        @(negedge clk);
        chk({30'h0, io_forward_valid, io_forward}, {30'h0, 1'h1, e});
    endtask
    task end_of_test;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_bus;
        req(12'h018, 1, 32'hFFA55AC3, 4'hF);
        rd(12'h018, 32'h00A55AC3);
        req(12'h019, 1, 32'h00003C00, 4'h2);
        rd(12'h018, 32'h00A53CC3);
        chk({upstream_bus_number, downstream_bus_number, highest_bus_behind}, 32'hC33CA5);
        req(12'h200, 1, 32'hFFFFFFFF, 4'hF);
        rd(12'h200, 32'h0);
    endtask
    task t_window;
        req(12'h01C, 1, 32'hFFFFFFFF, 4'h3);
        rd(12'h01C, 32'h0000F1F1);
        req(12'h01C, 1, 32'h00003010, 4'h3);
        rd(12'h01C, 32'h00003111);
        dec(32'h00000FFF, 0);
        dec(32'h00001000, 1);
        dec(32'h00003FFF, 1);
        dec(32'h00004000, 0);
    endtask
    task t_lock;
        req(12'h100, 1, 32'h1, 4'hF);
        req(12'h01C, 1, 32'h00000010, 4'h1);
        rd(12'h01C, 32'h00003010);
        chk({31'h0, io_addressing_capability}, 32'h0);
        dec(32'h00012000, 0);
        dec(32'h00002000, 1);
        req(12'h01C, 1, 32'h00002050, 4'h3);
        dec(32'h00003000, 0);
        dec(32'h00005000, 0);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1;
        rd(12'h018, 32'h0);
        rd(12'h01C, 32'h000001F1);
        chk({31'h0, io_addressing_capability}, 32'h1);
        t_bus;
        t_window;
        t_lock;
        end_of_test;
    end
endmodule // bbnio_regs_tb_top
